// ===== core/emp_edge.sv
`timescale 1ns/1ps
module emp_edge (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic level,
    output logic rise
);
    import emp_pkg::*;
    logic prev_q;

    // Pin clocks are sampled like data; one rise per low-to-high step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end
    assign rise = level & ~prev_q;
endmodule

// ===== core/emp_mdio_eng.sv
`timescale 1ns/1ps
module emp_mdio_eng (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] div_sel,
    input wire logic start,
    input wire emp_pkg::emp_mcmd_t cmd,
    input wire logic mdio_i,
    output logic busy,
    output logic [15:0] rdata,
    output logic mdc,
    output logic mdio_o,
    output logic mdio_oe
);
    import emp_pkg::*;
    typedef enum logic {ME_IDLE, ME_RUN} emp_mstate_t;
    emp_mstate_t st_q;
    logic [9:0] cnt_q;
    logic [5:0] bit_q;
    logic [63:0] sr_q;
    logic rd_q;
    logic [9:0] half;
    logic tick;
    logic [63:0] frame;
    logic [5:0] bit_nx;

    assign half = MDC_HALF_MIN << div_sel;
    // A divider change mid-frame must not strand the count past its end
    assign tick = (st_q == ME_RUN) && (cnt_q >= half - 10'h001);
    assign bit_nx = bit_q + 6'h01;
    assign frame = {MF_PREAMBLE, MF_START, cmd.op_read ? MF_OP_RD : MF_OP_WR,
                    cmd.phy, cmd.regad, MF_TA_WR, cmd.wdata};
    assign busy = (st_q == ME_RUN);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ME_IDLE;
            cnt_q <= 10'h000;
            bit_q <= 6'h00;
            sr_q <= 64'h0;
            rd_q <= 1'b0;
            rdata <= 16'h0000;
            mdc <= 1'b0;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
        end else begin
            case (st_q)
                ME_IDLE: begin
                    if (start) begin
                        st_q <= ME_RUN;
                        sr_q <= frame;
                        rd_q <= cmd.op_read;
                        bit_q <= 6'h00;
                        cnt_q <= 10'h000;
                        mdio_o <= frame[63];
                        mdio_oe <= 1'b1;
                    end
                end
                ME_RUN: begin
                    cnt_q <= tick ? 10'h000 : cnt_q + 10'h001;
                    if (tick && !mdc) begin
                        mdc <= 1'b1;
                        // PHY drives data after our falling edge
                        if (rd_q && bit_q >= MF_DATA_BIT) begin
                            rdata <= {rdata[14:0], mdio_i};
                        end
                    end else if (tick) begin
                        mdc <= 1'b0;
                        if (bit_q == MF_LAST_BIT) begin
                            st_q <= ME_IDLE;
                            mdio_oe <= 1'b0;
                        end else begin
                            bit_q <= bit_nx;
                            sr_q <= {sr_q[62:0], 1'b0};
                            mdio_o <= sr_q[62];
                            // Let go of the line for turnaround
                            mdio_oe <= !(rd_q && bit_nx >= MF_TA_BIT);
                        end
                    end
                end
                default: st_q <= ME_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_MDIO_RELEASE: assert property (
        (busy && rd_q && bit_q >= MF_TA_BIT && $past(bit_q) >= MF_TA_BIT)
            |-> !mdio_oe)
        else $error("mdio driven during read data phase");
    AST_MDC_ONLY_BUSY: assert property (
        $changed(mdc) |-> $past(busy) && $past(cnt_q) >= $past(half) - 10'h001)
        else $error("mdc edge outside divider terminal count");
endmodule

// ===== core/emp_pins.sv
`timescale 1ns/1ps
// What this block does
// - Codec mode uses only nibble bit 0
// - Codec mode mdc is loopback XOR alternate
// - Codec mode mdio follows cable type
// - Codec txd3, txd2 follow media select
// - Codec txd1 open collector, inverse power-down
// - Codec txer follows link disable
// - Codec status shows rxd3/2/1 at 12/15/13
// - Codec status shows rxer, rxdv at 11/10
// - MII transmit nibbles change on txclk
// - txen high exactly while nibble valid
// - txer flags errors in transmit stream
// - mdc divided from system clock by selector
// - mdio bidirectional serial, clocked by mdc
module emp_pins (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    input wire logic txclk,
    output logic [3:0] txd,
    output logic txd1_oe,
    output logic txen,
    output logic txer,
    input wire logic col,
    input wire logic crs,
    input wire logic rxclk,
    input wire logic [3:0] rxd,
    input wire logic rxer,
    input wire logic rxdv
);
    import emp_pkg::*;

    function automatic logic [31:0] mrg(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_have_q;
    logic w_have_q;
    emp_ctrl_t ctrl_q;
    emp_tx_t tx_q;
    emp_mcmd_t mcmd_q;
    logic [2:0] mcfg_q;
    logic tx_pend_q;
    logic [3:0] rx_nib_q;
    logic rx_new_q;
    logic mstart_q;

    logic wr_en;
    logic wr_hit;
    logic rd_fire;
    logic rd_hit;
    logic [31:0] stat_w;
    logic [31:0] rd_mux;
    logic codec;
    logic tx_rise;
    logic rx_rise;
    logic rx_take;
    logic rx_clr;
    logic tx_wr;
    logic eng_busy;
    logic [15:0] eng_rdata;
    logic eng_mdc;
    logic eng_mdio_o;
    logic eng_mdio_oe;

    assign codec = ctrl_q.serial_codec_mode;
    assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_hit = awaddr_q inside {ADDR_CTRL, ADDR_STAT, ADDR_MCFG,
                    ADDR_MCMD, ADDR_MRD, ADDR_TXD, ADDR_RXD};
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_hit = s_axi_araddr inside {ADDR_CTRL, ADDR_STAT, ADDR_MCFG,
                    ADDR_MCMD, ADDR_MRD, ADDR_TXD, ADDR_RXD};
    assign tx_wr = wr_en && awaddr_q == ADDR_TXD;
    assign rx_take = rx_rise && (rxdv || codec);
    assign rx_clr = rd_fire && s_axi_araddr == ADDR_RXD;

    // rxd3/2/1, rxer and rxdv show directly in codec mode; zero otherwise
    always_comb begin
        stat_w = 32'h0;
        stat_w[ST_CRS] = crs;
        stat_w[ST_COL] = col;
        stat_w[ST_MBUSY] = eng_busy;
        stat_w[ST_TXPEND] = tx_pend_q;
        stat_w[ST_RXNEW] = rx_new_q;
        if (codec) begin
            stat_w[ST_RXD3] = rxd[3];
            stat_w[ST_RXD2] = rxd[2];
            stat_w[ST_RXD1] = rxd[1];
            stat_w[ST_RXER] = rxer;
            stat_w[ST_RXDV] = rxdv;
        end
    end

    always_comb begin
        case (s_axi_araddr)
            ADDR_CTRL: rd_mux = {24'h0, ctrl_q};
            ADDR_STAT: rd_mux = stat_w;
            ADDR_MCFG: rd_mux = {29'h0, mcfg_q};
            ADDR_MCMD: rd_mux = {5'h0, mcmd_q};
            ADDR_MRD: rd_mux = {16'h0, eng_rdata};
            ADDR_TXD: rd_mux = {26'h0, tx_q};
            ADDR_RXD: rd_mux = {27'h0, rx_new_q, rx_nib_q};
            default: rd_mux = 32'h0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel; address and data may come in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Commands written while the engine is busy are dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTRL_RST;
            mcfg_q <= MCFG_RST;
            mcmd_q <= '0;
            mstart_q <= 1'b0;
            tx_q <= TX_RST;
        end else begin
            mstart_q <= wr_en && awaddr_q == ADDR_MCMD && !eng_busy;
            if (wr_en && awaddr_q == ADDR_CTRL) begin
                ctrl_q <= emp_ctrl_t'(mrg({24'h0, ctrl_q}, wdata_q,
                                          wstrb_q));
            end
            if (wr_en && awaddr_q == ADDR_MCFG) begin
                mcfg_q <= 3'(mrg({29'h0, mcfg_q}, wdata_q, wstrb_q));
            end
            if (wr_en && awaddr_q == ADDR_MCMD && !eng_busy) begin
                mcmd_q <= emp_mcmd_t'(mrg({5'h0, mcmd_q}, wdata_q,
                                          wstrb_q));
            end
            if (tx_wr) begin
                tx_q <= emp_tx_t'(mrg({26'h0, tx_q}, wdata_q, wstrb_q));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit and receive, stepped by sampled PHY clock edges; codec-mode pins follow ctrl_q every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pend_q <= 1'b0;
            rx_new_q <= 1'b0;
            rx_nib_q <= 4'h0;
            txd <= 4'h0;
            txd1_oe <= 1'b1;
            txen <= 1'b0;
            txer <= 1'b0;
        end else begin
            // A fresh write beats a nibble taken in the same cycle
            tx_pend_q <= tx_wr || (tx_pend_q && !tx_rise);
            rx_new_q <= rx_take || (rx_new_q && !rx_clr);
            if (rx_take) begin
                rx_nib_q <= codec ? {3'h0, rxd[0]} : rxd;
            end
            if (tx_rise) begin
                txen <= tx_pend_q && tx_q.txen;
                txd[0] <= tx_pend_q && tx_q.nibble[0];
            end
            if (codec) begin
                txd[3] <= ctrl_q.media_select_field[0];
                txd[2] <= ctrl_q.media_select_field[1];
                // Pin pulled low only; high level comes from pull-up
                txd[1] <= 1'b0;
                txd1_oe <= ctrl_q.power_down_ctrl;
                txer <= ctrl_q.link_disable_ctrl;
            end else begin
                txd1_oe <= 1'b1;
                if (tx_rise) begin
                    txd[3:1] <= tx_pend_q ? tx_q.nibble[3:1] : 3'h0;
                    txer <= tx_pend_q && tx_q.txer;
                end
            end
        end
    end

    // Management pins: engine in MII mode, plain outputs in codec mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mdc <= 1'b0;
            mdio_o <= 1'b0;
            mdio_oe <= 1'b0;
        end else if (codec) begin
            mdc <= ctrl_q.loopback_ctrl ^ ctrl_q.alt_transceiver_mode;
            mdio_o <= ctrl_q.cable_type_sel;
            mdio_oe <= 1'b1;
        end else begin
            mdc <= eng_mdc;
            mdio_o <= eng_mdio_o;
            mdio_oe <= eng_mdio_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    emp_edge u_txe (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(txclk),
        .rise(tx_rise)
    );
    emp_edge u_rxe (
        .aclk(aclk),
        .aresetn(aresetn),
        .level(rxclk),
        .rise(rx_rise)
    );
    emp_mdio_eng u_eng (
        .aclk(aclk),
        .aresetn(aresetn),
        .div_sel(mcfg_q),
        .start(mstart_q),
        .cmd(mcmd_q),
        .mdio_i(mdio_i),
        .busy(eng_busy),
        .rdata(eng_rdata),
        .mdc(eng_mdc),
        .mdio_o(eng_mdio_o),
        .mdio_oe(eng_mdio_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_codec_steady;
        codec && $past(codec);
    endsequence
    sequence s_stat_rd;
        rd_fire && s_axi_araddr == ADDR_STAT && codec;
    endsequence

    AST_CODEC_MDC: assert property (s_codec_steady |->
        mdc == ($past(ctrl_q.loopback_ctrl) ^ $past(ctrl_q.alt_transceiver_mode)))
        else $error("codec mdc not loopback xor alternate");
    AST_CODEC_MDIO: assert property (s_codec_steady |->
        mdio_oe && mdio_o == $past(ctrl_q.cable_type_sel))
        else $error("codec mdio not cable type");
    AST_CODEC_MEDIA: assert property (s_codec_steady |->
        txd[3:2] == {$past(ctrl_q.media_select_field[0]),
                     $past(ctrl_q.media_select_field[1])})
        else $error("codec txd3/txd2 not media select");
    AST_CODEC_PDN: assert property (s_codec_steady |->
        !txd[1] && txd1_oe == $past(ctrl_q.power_down_ctrl))
        else $error("codec txd1 not inverse power-down");
    AST_CODEC_TXER: assert property (s_codec_steady |->
        txer == $past(ctrl_q.link_disable_ctrl))
        else $error("codec txer not link disable");
    AST_STAT_MAP: assert property (s_stat_rd |=> s_axi_rvalid &&
        s_axi_rdata[15] == $past(rxd[2]) && s_axi_rdata[13] == $past(rxd[1])
        && s_axi_rdata[12] == $past(rxd[3]) && s_axi_rdata[11] == $past(rxer)
        && s_axi_rdata[10] == $past(rxdv))
        else $error("status pin map wrong");
    AST_TX_ON_CLK: assert property (!$past(tx_rise) |->
        $stable(txen) && $stable(txd[0]))
        else $error("transmit output moved without txclk");
    AST_TXEN_VALID: assert property ($past(tx_rise) |->
        txen == ($past(tx_pend_q) && $past(tx_q.txen)))
        else $error("txen not matching pending nibble");
    AST_RX_DV: assert property ($rose(rx_new_q) |->
        $past(rx_rise) && ($past(rxdv) || $past(codec)))
        else $error("nibble taken without rxdv");
endmodule

// ===== core/emp_pkg.sv
package emp_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_MCFG = 8'h08;
    localparam logic [7:0] ADDR_MCMD = 8'h0c;
    localparam logic [7:0] ADDR_MRD = 8'h10;
    localparam logic [7:0] ADDR_TXD = 8'h14;
    localparam logic [7:0] ADDR_RXD = 8'h18;
    // General status bit positions
    localparam int ST_CRS = 0;
    localparam int ST_COL = 1;
    localparam int ST_MBUSY = 2;
    localparam int ST_TXPEND = 3;
    localparam int ST_RXNEW = 4;
    localparam int ST_RXDV = 10;
    localparam int ST_RXER = 11;
    localparam int ST_RXD3 = 12;
    localparam int ST_RXD1 = 13;
    localparam int ST_RXD2 = 15;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Management frame
    localparam logic [5:0] MF_LAST_BIT = 6'h3f;
    localparam logic [5:0] MF_TA_BIT = 6'h2e;
    localparam logic [5:0] MF_DATA_BIT = 6'h30;
    localparam logic [31:0] MF_PREAMBLE = 32'hffff_ffff;
    localparam logic [1:0] MF_START = 2'h1;
    localparam logic [1:0] MF_OP_RD = 2'h2;
    localparam logic [1:0] MF_OP_WR = 2'h1;
    localparam logic [1:0] MF_TA_WR = 2'h2;
    localparam logic [9:0] MDC_HALF_MIN = 10'h002;
    localparam logic [2:0] MCFG_RST = 3'h7;

    typedef struct packed {
        logic link_disable_ctrl;
        logic power_down_ctrl;
        logic [1:0] media_select_field;
        logic cable_type_sel;
        logic loopback_ctrl;
        logic alt_transceiver_mode;
        logic serial_codec_mode;
    } emp_ctrl_t;

    typedef struct packed {
        logic txer;
        logic txen;
        logic [3:0] nibble;
    } emp_tx_t;

    typedef struct packed {
        logic op_read;
        logic [4:0] phy;
        logic [4:0] regad;
        logic [15:0] wdata;
    } emp_mcmd_t;

    localparam emp_ctrl_t CTRL_RST = '0;
    localparam emp_tx_t TX_RST = '0;
endpackage

// ===== verification/emp_phy_model.sv
`timescale 1ns/1ps
module emp_phy_model (
    input wire logic aclk,
    input wire logic mdc,
    input wire logic mdio_o,
    input wire logic mdio_oe,
    input wire logic rd_arm,
    input wire logic [15:0] rd_val,
    output logic mdio_i,
    output logic txclk,
    output logic rxclk,
    output logic [3:0] rxd,
    output logic rxdv,
    output logic rxer,
    output logic col,
    output logic crs
);
    logic [1:0] div_q = 2'h0;
    logic seen_q = 1'b0;
    logic drv_q = 1'b0;
    logic [4:0] nf_q = 5'h00;
    logic [16:0] sh_q = 17'h00000;
    initial begin
        rxd = 4'h0;
        rxdv = 1'b0;
        rxer = 1'b0;
        col = 1'b0;
        crs = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Line clocks run free with a four-cycle period
    always @(posedge aclk) div_q <= div_q + 2'h1;
    assign txclk = div_q[1];
    assign rxclk = div_q[1];
    // Pull-up holds the line high whenever nobody drives it
    assign mdio_i = mdio_oe ? mdio_o : (drv_q ? sh_q[16] : 1'b1);
    ////////////////////////////////////////////////////////////////////////
    // Step on the pin's falling mdc, as a PHY does, so each read bit
    // stands before the device samples it; count only after the device
    // has driven the line and then let go
    always @(posedge rd_arm or negedge mdc) begin
        if (!rd_arm || mdio_oe || !seen_q) begin
            seen_q <= rd_arm && (mdio_oe || seen_q);
            drv_q <= 1'b0;
            nf_q <= 5'h00;
            sh_q <= {1'b0, rd_val};
        end else if (nf_q < 5'h13) begin
            nf_q <= nf_q + 5'h01;
            if (nf_q == 5'h01) drv_q <= 1'b1;
            else if (nf_q == 5'h12) drv_q <= 1'b0;
            else if (nf_q > 5'h01) sh_q <= sh_q << 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic put_rx(input logic [3:0] n, input logic dv, input logic er);
        @(negedge rxclk);
        rxd <= n;
        rxdv <= dv;
        rxer <= er;
        crs <= dv;
        @(posedge rxclk);
        repeat (2) @(posedge aclk);
    endtask
    task automatic set_col(input logic c);
        @(posedge aclk);
        col <= c;
        repeat (3) @(posedge aclk);
    endtask
endmodule

// ===== verification/ethernet_mii_serial_codec_mode_pin_interface_tb.sv
`timescale 1ns/1ps
module ethernet_mii_serial_codec_mode_pin_interface_tb;
    import emp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, rd_arm = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, mdc_p;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [15:0] rd_val = 16'h0000;
    logic mdc, mdio_i, mdio_o, mdio_oe, txclk, txd1_oe, txen, txer;
    logic col, crs, rxclk, rxer, rxdv;
    logic [3:0] txd, rxd;
    int n_errors = 0, check_count = 0, n_rise = 0;
    always #50 aclk = ~aclk;
    emp_pins dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mdc, .mdio_i, .mdio_o,
        .mdio_oe, .txclk, .txd, .txd1_oe, .txen, .txer, .col, .crs, .rxclk,
        .rxd, .rxer, .rxdv);
    emp_phy_model phy (.aclk, .mdc, .mdio_o, .mdio_oe, .rd_arm, .rd_val,
        .mdio_i, .txclk, .rxclk, .rxd, .rxdv, .rxer, .col, .crs);
    always @(posedge aclk) begin
        mdc_p <= mdc;
        if (mdc && !mdc_p) n_rise++;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Polls a status bit until it drops; the watchdog bounds the wait
    task automatic wait_clr(input int b);
        do rd(ADDR_STAT); while (rv[b] !== 1'b0);
    endtask
    task finish_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        finish_test;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CTRL);
        chk(rv, 32'h0);
        rd(ADDR_MCFG);
        chk(rv, 32'h7);
        wr(8'h1c, 32'h1);
        chk(32'(resp), 32'(RESP_DECERR));
        rd(8'h1c);
        chk({rv[29:0], resp}, 32'(RESP_DECERR));
        // MII transmit: one nibble, then idle after the next txclk rise
        wr(ADDR_TXD, 32'h3a);
        wait_clr(ST_TXPEND);
        chk(32'({txer, txen, txd}), 32'h3a);
        repeat (2) @(posedge txclk);
        @(posedge aclk);
        chk(32'({txer, txen, txd}), 32'h0);
        // MII receive and line status
        phy.put_rx(4'h5, 1'b1, 1'b0);
        rd(ADDR_STAT);
        chk(32'(rv[ST_CRS]), 32'h1);
        phy.put_rx(4'h9, 1'b0, 1'b0);
        rd(ADDR_RXD);
        chk(rv, 32'h15);
        rd(ADDR_RXD);
        chk(rv, 32'h05);
        phy.set_col(1'b1);
        rd(ADDR_STAT);
        chk(32'(rv[ST_COL]), 32'h1);
        phy.set_col(1'b0);
        // Management write then read at the fastest divider
        wr(ADDR_MCFG, 32'h0);
        wr(ADDR_MCMD, 32'h0023_1234);
        wait_clr(ST_MBUSY);
        rd_val <= 16'hbeef;
        rd_arm <= 1'b1;
        n_rise = 0;
        wr(ADDR_MCMD, 32'h0422_0000);
        wait_clr(ST_MBUSY);
        chk(32'(n_rise), 32'd64);
        rd(ADDR_MRD);
        chk(rv, 32'hbeef);
        rd_arm <= 1'b0;
        // Codec mode general-purpose pins, two opposite settings
        wr(ADDR_CTRL, 32'hdd);
        repeat (4) @(posedge aclk);
        chk(32'({mdc, mdio_o, mdio_oe, txd[3:1], txd1_oe, txer}), 32'hf3);
        wr(ADDR_CTRL, 32'h27);
        repeat (4) @(posedge aclk);
        chk(32'({mdc, mdio_o, mdio_oe, txd[3:1], txd1_oe, txer}), 32'h28);
        wr(ADDR_TXD, 32'h01);
        wait_clr(ST_TXPEND);
        chk(32'(txd), 32'h5);
        phy.put_rx(4'he, 1'b1, 1'b1);
        rd(ADDR_STAT);
        chk(rv & 32'hbc00, 32'hbc00);
        rd(ADDR_RXD);
        chk(rv, 32'h10);
        phy.put_rx(4'h1, 1'b0, 1'b0);
        rd(ADDR_STAT);
        chk(rv & 32'hbc00, 32'h0);
        rd(ADDR_RXD);
        chk(rv, 32'h11);
        finish_test;
    end
endmodule
